// ### core/bic_pkg.sv
package bic_pkg;

    // Register offsets on the plain register port
    localparam logic [2:0] ADDR_CTRL_ONE = 3'h0;
    localparam logic [2:0] ADDR_CTRL_TWO = 3'h1;
    localparam logic [2:0] ADDR_DATA = 3'h2;
    localparam logic [2:0] ADDR_STATUS = 3'h3;
    localparam logic [2:0] ADDR_PORT = 3'h4;
    localparam logic [2:0] ADDR_PIN_LEVEL = 3'h5;

    // bus_interface_control_one fields
    localparam int C1_STOP_IE = 0;
    localparam int C1_WAIT_EN = 1;
    localparam int C1_SDA_OVR = 2;
    localparam int C1_SCL_OVR = 3;
    localparam int C1_SDA_MON = 4;
    localparam int C1_SCL_MON = 5;
    localparam int C1_LO0 = 6;
    localparam int C1_LO1 = 7;

    // bus_interface_control_two fields
    localparam int C2_ACK_BIT = 0;
    localparam int C2_ACK_CLK = 1;
    localparam int C2_TRANSMIT = 2;
    localparam int C2_HI0 = 3;
    localparam int C2_HI2 = 5;
    localparam int C2_SRC_SEL = 6;
    localparam int C2_ENABLE = 7;

    // Port register fields
    localparam int PORT_LATCH0 = 0;
    localparam int PORT_LATCH1 = 1;
    localparam int PORT_DIR0 = 2;
    localparam int PORT_DIR1 = 3;

    // Values after reset
    localparam logic [7:0] CTRL_ONE_RST = 8'h00;
    localparam logic [7:0] CTRL_TWO_RST = 8'h00;
    localparam logic [7:0] PORT_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;

    // Bit counts
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    // Divider select codes
    localparam logic [1:0] LO_DIV_2 = 2'h0;
    localparam logic [1:0] LO_DIV_4 = 2'h1;
    localparam logic [1:0] LO_DIV_8 = 2'h2;
    localparam logic [2:0] HI_LOW_SET = 3'h0;
    localparam logic [2:0] HI_DIV_2_5 = 3'h1;
    localparam logic [2:0] HI_DIV_3 = 3'h2;
    localparam logic [2:0] HI_DIV_5 = 3'h3;
    localparam logic [2:0] HI_DIV_6 = 3'h4;

    // Divider terminal counts (period minus one, in source ticks)
    localparam logic [2:0] TERM_2 = 3'h1;
    localparam logic [2:0] TERM_3 = 3'h2;
    localparam logic [2:0] TERM_4 = 3'h3;
    localparam logic [2:0] TERM_5 = 3'h4;
    localparam logic [2:0] TERM_6 = 3'h5;
    localparam logic [2:0] TERM_8 = 3'h7;

    typedef struct packed {
        logic out;
        logic oe;
    } bic_pin_drv_t;

    typedef struct packed {
        logic [2:0] hi;
        logic [1:0] lo;
    } bic_div_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BITS,
        ST_ACK
    } bic_state_t;

endpackage

// ### core/bic_clk_div.sv
`timescale 1ns/100ps
module bic_clk_div (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic run,
    input wire logic src_sel,
    input wire bic_pkg::bic_div_sel_t div_sel,
    output logic tick
);
    logic src_phase;
    logic half_alt;
    logic [2:0] cnt;
    wire src_tick;
    wire [2:0] term;

    // Source select 0 takes every cycle, 1 every second cycle
    assign src_tick = !src_sel || src_phase;

    // Ratio 1/2.5 alternates periods of 2 and 3 source ticks
    assign term = (div_sel.hi == bic_pkg::HI_DIV_2_5) ? (half_alt ? bic_pkg::TERM_3
                                                                   : bic_pkg::TERM_2) :
                  (div_sel.hi == bic_pkg::HI_DIV_3) ? bic_pkg::TERM_3 :
                  (div_sel.hi == bic_pkg::HI_DIV_5) ? bic_pkg::TERM_5 :
                  (div_sel.hi == bic_pkg::HI_DIV_6) ? bic_pkg::TERM_6 :
                  (div_sel.lo == bic_pkg::LO_DIV_4) ? bic_pkg::TERM_4 :
                  (div_sel.lo == bic_pkg::LO_DIV_8) ? bic_pkg::TERM_8 :
                  bic_pkg::TERM_2;

    always_ff @(posedge sys_clk) begin
        if (srst || !run) begin
            src_phase <= 1'b0;
            half_alt <= 1'b0;
            cnt <= 3'h0;
            tick <= 1'b0;
        end else begin
            src_phase <= ~src_phase;
            tick <= 1'b0;
            if (src_tick) begin
                if (cnt >= term) begin
                    cnt <= 3'h0;
                    tick <= 1'b1;
                    half_alt <= ~half_alt;
                end else begin
                    cnt <= cnt + 3'h1;
                end
            end
        end
    end
endmodule

// ### core/bic_ctrl_one.sv
`timescale 1ns/100ps
module bic_ctrl_one (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic sda_in,
    input wire logic scl_in,
    output bic_pkg::bic_pin_drv_t sda_drv,
    output bic_pkg::bic_pin_drv_t scl_drv,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic low_power_mode,
    input wire logic stop_clock_in_wait,
    output logic bus_irq
);
    logic [7:0] ctrl_one;
    logic [7:0] ctrl_two;
    logic [7:0] port_reg;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic pending;
    logic wait_flag;
    logic addr_phase;
    logic sda_int;
    logic scl_int;
    bic_pkg::bic_state_t state;

    logic sda_s1;
    logic sda_s2;
    logic scl_s1;
    logic scl_s2;
    logic sda_q;
    logic scl_q;
    logic tick;

    logic [7:0] next_shift;
    logic [3:0] next_bit_cnt;
    logic next_pending;
    logic next_wait_flag;
    logic next_addr_phase;
    logic next_sda_int;
    logic next_irq;
    bic_pkg::bic_state_t next_state;

    wire wr_c1;
    wire wr_c2;
    wire wr_data;
    wire wr_port;
    wire enable;
    wire stop_ie;
    wire wait_en;
    wire sda_ovr;
    wire scl_ovr;
    wire ack_clk;
    wire ack_bit;
    wire transmit;
    wire run;
    wire scl_fall;
    wire scl_rise;
    wire start_det;
    wire stop_det;
    wire rx_wait_ok;
    wire [7:0] c1_view;
    wire [7:0] status_view;
    wire [7:0] next_rdata;
    bic_pkg::bic_div_sel_t div_sel;
    bic_pkg::bic_pin_drv_t next_sda_drv;
    bic_pkg::bic_pin_drv_t next_scl_drv;

    // Register write decode
    assign wr_c1 = reg_wr && (reg_addr == bic_pkg::ADDR_CTRL_ONE);
    assign wr_c2 = reg_wr && (reg_addr == bic_pkg::ADDR_CTRL_TWO);
    assign wr_data = reg_wr && (reg_addr == bic_pkg::ADDR_DATA);
    assign wr_port = reg_wr && (reg_addr == bic_pkg::ADDR_PORT);

    assign enable = ctrl_two[bic_pkg::C2_ENABLE];
    assign stop_ie = ctrl_one[bic_pkg::C1_STOP_IE];
    assign wait_en = ctrl_one[bic_pkg::C1_WAIT_EN];
    assign sda_ovr = ctrl_one[bic_pkg::C1_SDA_OVR];
    assign scl_ovr = ctrl_one[bic_pkg::C1_SCL_OVR];
    assign ack_clk = ctrl_two[bic_pkg::C2_ACK_CLK];
    assign ack_bit = ctrl_two[bic_pkg::C2_ACK_BIT];
    assign transmit = ctrl_two[bic_pkg::C2_TRANSMIT];

    // Divider select: upper three bits in control two, lower two in control one
    assign div_sel = {ctrl_two[bic_pkg::C2_HI2:bic_pkg::C2_HI0],
                      ctrl_one[bic_pkg::C1_LO1], ctrl_one[bic_pkg::C1_LO0]};

    // Interface clock stops in stop and low-power modes, and in wait mode if gated
    assign run = enable && !stop_mode && !low_power_mode
                 && !(wait_mode && stop_clock_in_wait);

    bic_clk_div u_div (
        .sys_clk(sys_clk),
        .srst(srst),
        .run(run),
        .src_sel(ctrl_two[bic_pkg::C2_SRC_SEL]),
        .div_sel(div_sel),
        .tick(tick)
    );

    // Bus events seen at the divided rate
    assign scl_fall = tick && scl_q && !scl_s2;
    assign scl_rise = tick && !scl_q && scl_s2;
    assign start_det = tick && scl_q && scl_s2 && sda_q && !sda_s2;
    assign stop_det = tick && scl_q && scl_s2 && !sda_q && sda_s2;

    // Early wait only for received data bytes, never address or transmit
    assign rx_wait_ok = wait_en && ack_clk && !transmit && !addr_phase;

    always_comb begin
        next_shift = shift;
        next_bit_cnt = bit_cnt;
        next_pending = pending;
        next_wait_flag = wait_flag;
        next_addr_phase = addr_phase;
        next_sda_int = sda_int;
        next_irq = 1'b0;
        next_state = state;
        if (!enable) begin
            next_pending = 1'b1;
            next_wait_flag = 1'b0;
            next_addr_phase = 1'b0;
            next_bit_cnt = 4'h0;
            next_sda_int = 1'b1;
            next_state = bic_pkg::ST_IDLE;
        end else begin
            // Byte-end clears of pending below take priority over these sets
            if (wr_data) begin
                next_pending = 1'b1;
                next_shift = reg_wdata;
                if (!transmit && !addr_phase) begin
                    next_wait_flag = 1'b1;
                end
            end
            if (wr_c2) begin
                next_wait_flag = 1'b0;
                if (wait_en && wait_flag) begin
                    next_pending = 1'b1;
                end
            end
            // A START clears the wait flag even over a same-cycle data write
            if (start_det) begin
                next_state = bic_pkg::ST_BITS;
                next_bit_cnt = 4'h0;
                next_addr_phase = 1'b1;
                next_wait_flag = 1'b0;
                next_sda_int = 1'b1;
            end else if (stop_det) begin
                next_state = bic_pkg::ST_IDLE;
                next_bit_cnt = 4'h0;
                next_addr_phase = 1'b0;
                next_sda_int = 1'b1;
                if (stop_ie) begin
                    next_irq = 1'b1;
                end
            end else if (scl_rise && state == bic_pkg::ST_BITS) begin
                next_bit_cnt = bit_cnt + 4'h1;
                if (!transmit) begin
                    next_shift = {shift[6:0], sda_s2};
                end
            end else if (scl_fall && state == bic_pkg::ST_BITS) begin
                if (bit_cnt == bic_pkg::BITS_PER_BYTE) begin
                    if (!ack_clk) begin
                        next_pending = 1'b0;
                        next_irq = 1'b1;
                        next_bit_cnt = 4'h0;
                        next_addr_phase = 1'b0;
                        next_sda_int = 1'b1;
                    end else begin
                        next_state = bic_pkg::ST_ACK;
                        next_sda_int = transmit ? 1'b1 : ack_bit;
                        if (rx_wait_ok && wait_flag) begin
                            next_pending = 1'b0;
                            next_irq = 1'b1;
                        end
                    end
                end else if (transmit) begin
                    next_sda_int = shift[3'h7 - bit_cnt[2:0]];
                end
            end else if (scl_fall && state == bic_pkg::ST_ACK) begin
                next_state = bic_pkg::ST_BITS;
                next_bit_cnt = 4'h0;
                next_addr_phase = 1'b0;
                next_sda_int = 1'b1;
                next_pending = 1'b0;
                next_irq = 1'b1;
            end
        end
    end

    // Pin function: port, bus, or bus input with port latch driving the line
    always_comb begin
        if (!enable) begin
            next_sda_drv.out = port_reg[bic_pkg::PORT_LATCH0];
            next_sda_drv.oe = port_reg[bic_pkg::PORT_DIR0];
            next_scl_drv.out = port_reg[bic_pkg::PORT_LATCH1];
            next_scl_drv.oe = port_reg[bic_pkg::PORT_DIR1];
        end else begin
            // Open drain on the bus: pull low or release
            next_sda_drv.out = 1'b0;
            next_scl_drv.out = 1'b0;
            if (sda_ovr) begin
                next_sda_drv.oe = !port_reg[bic_pkg::PORT_LATCH0];
            end else begin
                next_sda_drv.oe = !sda_int;
            end
            if (scl_ovr) begin
                next_scl_drv.oe = !port_reg[bic_pkg::PORT_LATCH1];
            end else begin
                next_scl_drv.oe = !scl_int;
            end
        end
    end

    // Read views
    assign c1_view = {ctrl_one[bic_pkg::C1_LO1], ctrl_one[bic_pkg::C1_LO0],
                      scl_int, sda_int,
                      scl_ovr, sda_ovr, wait_flag, stop_ie};
    assign status_view = {1'b0, state == bic_pkg::ST_ACK, bit_cnt[3:0],
                          addr_phase, pending};
    assign next_rdata = !reg_rd ? 8'h00 :
                        (reg_addr == bic_pkg::ADDR_CTRL_ONE) ? c1_view :
                        (reg_addr == bic_pkg::ADDR_CTRL_TWO) ? ctrl_two :
                        (reg_addr == bic_pkg::ADDR_DATA) ? shift :
                        (reg_addr == bic_pkg::ADDR_STATUS) ? status_view :
                        (reg_addr == bic_pkg::ADDR_PORT) ? port_reg :
                        (reg_addr == bic_pkg::ADDR_PIN_LEVEL) ? {6'h00, scl_s2, sda_s2} :
                        8'h00;

    // Pin synchronisers run every cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
        end else begin
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
        end
    end

    // Line levels sampled at the divided rate for edge detection
    // While halted they follow the lines, so a restart sees no stale edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sda_q <= 1'b1;
            scl_q <= 1'b1;
        end else if (tick || !run) begin
            sda_q <= sda_s2;
            scl_q <= scl_s2;
        end
    end

    // Software registers; monitor bits and wait read-back are not stored
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_one <= bic_pkg::CTRL_ONE_RST;
            ctrl_two <= bic_pkg::CTRL_TWO_RST;
            port_reg <= bic_pkg::PORT_RST;
        end else begin
            if (wr_c1) begin
                ctrl_one <= reg_wdata & 8'hCF;
            end
            if (wr_c2) begin
                ctrl_two <= reg_wdata;
            end
            if (wr_port) begin
                port_reg <= reg_wdata & 8'h0F;
            end
        end
    end

    // Transfer engine state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= bic_pkg::ST_IDLE;
            shift <= bic_pkg::DATA_RST;
            bit_cnt <= 4'h0;
            pending <= 1'b1;
            wait_flag <= 1'b0;
            addr_phase <= 1'b0;
            sda_int <= 1'b1;
            scl_int <= 1'b1;
            bus_irq <= 1'b0;
        end else begin
            state <= next_state;
            shift <= next_shift;
            bit_cnt <= next_bit_cnt;
            pending <= next_pending;
            wait_flag <= next_wait_flag;
            addr_phase <= next_addr_phase;
            sda_int <= next_sda_int;
            // Clock line stays low until software sets pending again
            scl_int <= next_pending || !enable;
            bus_irq <= next_irq;
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sda_drv <= '0;
            scl_drv <= '0;
            reg_rdata <= 8'h00;
        end else begin
            sda_drv <= next_sda_drv;
            scl_drv <= next_scl_drv;
            reg_rdata <= next_rdata;
        end
    end
endmodule

// ### dv/bic_ctrl_one_props.sv
`timescale 1ns/100ps
module bic_ctrl_one_props (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sda_in,
    input wire logic scl_in,
    input wire bic_pkg::bic_pin_drv_t sda_drv,
    input wire bic_pkg::bic_pin_drv_t scl_drv,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic low_power_mode,
    input wire logic stop_clock_in_wait,
    input wire logic bus_irq
);
    logic [7:0] sh1, sh2, shp;
    logic [1:0] quiet;
    wire logic [1:0] next_quiet = reg_wr ? 2'h0 : quiet + {1'b0, quiet != 2'h3};
    wire logic en = sh2[bic_pkg::C2_ENABLE];
    wire logic calm = quiet == 2'h3;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Shadow copies of the writable registers, for relations on the pins
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sh1 <= bic_pkg::CTRL_ONE_RST;
            sh2 <= bic_pkg::CTRL_TWO_RST;
            shp <= bic_pkg::PORT_RST;
            quiet <= 2'h0;
        end else begin
            sh1 <= (reg_wr && reg_addr == bic_pkg::ADDR_CTRL_ONE) ? reg_wdata : sh1;
            sh2 <= (reg_wr && reg_addr == bic_pkg::ADDR_CTRL_TWO) ? reg_wdata : sh2;
            shp <= (reg_wr && reg_addr == bic_pkg::ADDR_PORT) ? reg_wdata : shp;
            quiet <= next_quiet;
        end
    end
    property p_ctrl1_rb;
        reg_rd && reg_addr == bic_pkg::ADDR_CTRL_ONE |=> (reg_rdata & 8'hCD) == ($past(sh1) & 8'hCD);
    endproperty
    a_ctrl1_rb: assert property (p_ctrl1_rb) else $error("control one readback wrong");
    property p_unmapped;
        reg_rd && reg_addr > bic_pkg::ADDR_PIN_LEVEL |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_ovr_sda;
        en && sh1[bic_pkg::C1_SDA_OVR] && calm |->
            sda_drv.oe == !shp[bic_pkg::PORT_LATCH0] && !(sda_drv.oe && sda_drv.out);
    endproperty
    a_ovr_sda: assert property (p_ovr_sda) else $error("sda override drive wrong");
    property p_ovr_scl;
        en && sh1[bic_pkg::C1_SCL_OVR] && calm |->
            scl_drv.oe == !shp[bic_pkg::PORT_LATCH1] && !(scl_drv.oe && scl_drv.out);
    endproperty
    a_ovr_scl: assert property (p_ovr_scl) else $error("scl override drive wrong");
    property p_port_mode;
        !en && calm |-> sda_drv.oe == shp[bic_pkg::PORT_DIR0] && scl_drv.oe == shp[bic_pkg::PORT_DIR1];
    endproperty
    a_port_mode: assert property (p_port_mode) else $error("port mode enable wrong");
    property p_irq_pulse;
        bus_irq |=> !bus_irq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
    property p_hold;
        $rose(scl_drv.oe) && en && !sh1[bic_pkg::C1_SCL_OVR] |->
            $past(bus_irq) || $past(bus_irq, 2) || $past(bus_irq, 3);
    endproperty
    a_hold: assert property (p_hold) else $error("clock held without interrupt");
    property p_halt;
        (stop_mode || low_power_mode) [*3] |-> !bus_irq;
    endproperty
    a_halt: assert property (p_halt) else $error("interrupt while halted");
    property p_resume;
        reg_wr && reg_addr == bic_pkg::ADDR_DATA && en && !sh1[bic_pkg::C1_SCL_OVR] && !stop_mode
            && !low_power_mode |-> ##[1:4] !scl_drv.oe;
    endproperty
    a_resume: assert property (p_resume) else $error("clock not released after data write");
    c_irq: cover property (bus_irq);
    c_ovr: cover property (en && sh1[bic_pkg::C1_SDA_OVR] && calm);
    c_hold: cover property ($rose(scl_drv.oe) && en);
endmodule
bind bic_ctrl_one bic_ctrl_one_props u_props (.sys_clk(sys_clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sda_in(sda_in), .scl_in(scl_in), .sda_drv(sda_drv),
    .scl_drv(scl_drv), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .low_power_mode(low_power_mode), .stop_clock_in_wait(stop_clock_in_wait), .bus_irq(bus_irq));

// ### dv/bic_bus_master.sv
`timescale 1ns/100ps
module bic_bus_master #(parameter int HALF = 40) (
    input wire logic sys_clk,
    input wire logic scl,
    output logic scl_low,
    output logic sda_low
);
    int fall_cnt;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        fall_cnt = 0;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // The device may stretch a released clock; wait for the high level, bounded
    task automatic rise();
        int n;
        n = 0;
        @(posedge sys_clk) scl_low <= 1'b0;
        while (scl !== 1'b1 && n < 20000) begin
            @(posedge sys_clk);
            n++;
        end
        idle(HALF);
    endtask
    task automatic fall();
        @(posedge sys_clk) scl_low <= 1'b1;
        fall_cnt++;
        idle(HALF);
    endtask
    task automatic start_cond();
        @(posedge sys_clk) sda_low <= 1'b1;
        idle(HALF);
        @(posedge sys_clk) scl_low <= 1'b1;
        idle(HALF);
    endtask
    // MSB first, then a ninth clock with data released for the acknowledge
    task automatic send_byte(input logic [7:0] b);
        fall_cnt = 0;
        for (int i = 8; i >= 0; i--) begin
            @(posedge sys_clk) sda_low <= (i > 0) ? !b[(i > 0) ? i - 1 : 0] : 1'b0;
            idle(HALF / 2);
            rise();
            fall();
        end
    endtask
    task automatic stop_cond();
        @(posedge sys_clk) sda_low <= 1'b1;
        idle(HALF);
        rise();
        @(posedge sys_clk) sda_low <= 1'b0;
        idle(HALF);
    endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/100ps
module testbench;
    localparam logic [2:0] A1 = bic_pkg::ADDR_CTRL_ONE;
    localparam logic [2:0] A2 = bic_pkg::ADDR_CTRL_TWO;
    localparam logic [2:0] AD = bic_pkg::ADDR_DATA;
    localparam logic [2:0] AP = bic_pkg::ADDR_PORT;
    localparam logic [7:0] C2 = {2'b11, bic_pkg::HI_DIV_6, 3'b010};
    logic sys_clk, srst, reg_wr, reg_rd, m_scl, m_sda, bus_irq;
    logic wait_mode, stop_mode, low_power_mode, stop_clock_in_wait;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    bic_pkg::bic_pin_drv_t sda_drv, scl_drv;
    int failures, checks_done, irq_cnt, c0;
    // Open-drain wires with pull-ups
    wire logic sda_w = !(m_sda || (sda_drv.oe && !sda_drv.out));
    wire logic scl_w = !(m_scl || (scl_drv.oe && !scl_drv.out));
    bic_ctrl_one uut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sda_in(sda_w), .scl_in(scl_w), .sda_drv(sda_drv), .scl_drv(scl_drv),
        .wait_mode(wait_mode), .stop_mode(stop_mode), .low_power_mode(low_power_mode),
        .stop_clock_in_wait(stop_clock_in_wait), .bus_irq(bus_irq));
    bic_bus_master bm (.sys_clk(sys_clk), .scl(scl_w), .scl_low(m_scl), .sda_low(m_sda));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = !sys_clk;
    end
    always @(posedge sys_clk) if (bus_irq === 1'b1) irq_cnt++;
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge sys_clk) reg_rd <= 1'b0;
        @(negedge sys_clk) rv = reg_rdata;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        checks_done++;
        if ((got & m) !== (exp & m)) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got & m, exp & m);
        end
    endtask
    task automatic wait_irq();
        int c;
        int n;
        c = irq_cnt;
        n = 0;
        while (irq_cnt == c && n < 30000) begin
            @(posedge sys_clk);
            n++;
        end
        @(negedge sys_clk) cmp(8'(irq_cnt - c), 8'h01, 8'hFF);
    endtask
    task automatic drv_chk(input logic [7:0] s, input logic [7:0] k, input logic [7:0] m);
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk) cmp({6'h00, sda_drv}, s, m);
        cmp({6'h00, scl_drv}, k, m);
    endtask
    task automatic results();
        $display("checks_done=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        failures++;
        results();
    end
    initial begin
        {srst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 3'h0, 8'h00};
        {wait_mode, stop_mode, low_power_mode, stop_clock_in_wait} = 4'h0;
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        rd(A1);
        cmp(rv, bic_pkg::CTRL_ONE_RST, 8'hCF);
        rd(A2);
        cmp(rv, bic_pkg::CTRL_TWO_RST, 8'hFF);
        wr(3'h6, 8'hFF);
        rd(3'h6);
        cmp(rv, 8'h00, 8'hFF);
        wr(A1, 8'hFF);
        rd(A1);
        cmp(rv, 8'hCD, 8'hCF);
        wr(A1, 8'h00);
        $display("test registers done");
        wr(AP, 8'h0E);
        drv_chk(8'h01, 8'h03, 8'h03);
        wr(A2, 8'h80);
        wr(A1, 8'h04);
        drv_chk(8'h01, 8'h00, 8'h03);
        rd(bic_pkg::ADDR_PIN_LEVEL);
        cmp(rv, 8'h02, 8'h03);
        wr(AP, 8'h01);
        wr(A1, 8'h08);
        drv_chk(8'h00, 8'h01, 8'h03);
        wr(A1, 8'h00);
        wr(AP, 8'h00);
        $display("test pins done");
        wait_mode <= 1'b1;
        wr(A2, C2);
        wr(A1, 8'h03);
        fork
            begin
                bm.start_cond();
                bm.send_byte(8'hA4);
                bm.send_byte(8'h5A);
                bm.stop_cond();
            end
            begin
                wait_irq();
                cmp(8'(bm.fall_cnt), 8'h09, 8'hFF);
                rd(A1);
                cmp(rv, 8'h00, 8'h22);
                cmp({6'h00, scl_drv}, 8'h01, 8'h03);
                wr(AD, 8'h00);
                wait_irq();
                cmp(8'(bm.fall_cnt), 8'h08, 8'hFF);
                rd(A1);
                cmp(rv, 8'h02, 8'h22);
                wr(A2, C2);
                rd(A1);
                cmp(rv, 8'h00, 8'h02);
                wait_irq();
                cmp(8'(bm.fall_cnt), 8'h09, 8'hFF);
                wr(AD, 8'h00);
                wait_irq();
            end
        join
        wait_mode <= 1'b0;
        $display("test receive wait done");
        for (int m = 0; m < 3; m++) begin
            @(posedge sys_clk) {stop_mode, low_power_mode, wait_mode, stop_clock_in_wait} <=
                (m == 0) ? 4'h8 : (m == 1) ? 4'h4 : 4'h3;
            c0 = irq_cnt;
            bm.start_cond();
            bm.send_byte(8'hA4);
            bm.stop_cond();
            cmp(8'(irq_cnt - c0), 8'h00, 8'hFF);
            cmp({6'h00, scl_drv}, 8'h00, 8'h01);
        end
        $display("test halted modes done");
        results();
    end
endmodule
